// *** hdl/qhsc_device.sv ***
// Purpose: Command decode and fault handling of a quad high-side switch
// Assumes: Link pins sampled on aclk; fault inputs are synchronous levels
// Notes:   One rule a line, tag first
`include "qhsc_defines.svh"
module qhsc_device
   import qhsc_pkg::*;
#(
   parameter int BLANK_150US = `QHSC_BLANK_150US,
   parameter int BLANK_75MS  = `QHSC_BLANK_75MS,
   parameter int BLANK_155MS = `QHSC_BLANK_155MS
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Link
   qhsc_if.dev             link,
   // Analog conditions
   input  wire logic       overvoltage,
   input  wire logic       undervoltage,
   input  wire logic [3:0] open_load,
   input  wire logic [3:0] oc_low_hit,
   input  wire logic [3:0] oc_high_hit,
   input  wire logic [3:0] direct_in,
   // Load side
   output logic [3:0]      out_on_r,
   output logic [3:0]      sense_en_r,
   output logic [15:0]     oc_level_r,
   output logic [15:0]     direct_cfg_r,
   output logic [1:0]      wd_timeout_r,
   output logic            wd_refresh_r,
   output logic            fault_status_out_n_r
);
   // Blanking counts must fit the 23-bit counters
   if (BLANK_150US < 1 || BLANK_75MS < 1 || BLANK_155MS < 1) begin : g_small
      $error("blanking counts must be positive");
   end
   if (BLANK_150US >= 2**23 || BLANK_75MS >= 2**23 || BLANK_155MS >= 2**23) begin : g_big
      $error("blanking counts exceed counter width");
   end
   logic [2:0]  sclk_s_r, cs_s_r;
   logic [1:0]  mosi_s_r;
   logic [15:0] shin_r, shout_r;
   logic [7:0]  cnt_r;
   logic [4:0]  stat_sel_r;
   logic [15:0] blank_cfg_r;
   logic [1:0]  vprot_dis_r;
   logic [3:0]  spi_on_r, oc_latch_r, ol_flag_r, on_prev_r;
   logic        ov_flag_r, uv_flag_r, uv_latch_r;
   logic [22:0] blank_cnt_r [4];
   logic        rise, fall, cs_rise, cs_fall, word_ok;
   logic [2:0]  sel;
   logic [1:0]  os;
   logic [15:0] status_word;
   logic [3:0]  req_on;
   logic [3:0]  ol_en;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_s_r <= 3'h0;
         cs_s_r   <= 3'h7;
         mosi_s_r <= 2'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], link.sclk};
         cs_s_r   <= {cs_s_r[1:0], link.cs_n};
         mosi_s_r <= {mosi_s_r[0], link.mosi};
      end
   end
   assign rise    = sclk_s_r[1] & ~sclk_s_r[2];
   assign fall    = ~sclk_s_r[1] & sclk_s_r[2];
   assign cs_fall = ~cs_s_r[1] & cs_s_r[2];
   assign cs_rise = cs_s_r[1] & ~cs_s_r[2];
   // Frames that are not whole words are dropped
   assign word_ok = cs_rise && cnt_r != 8'h0 && cnt_r[3:0] == 4'h0;
   assign sel     = shin_r[`QHSC_SEL_HI:`QHSC_SEL_LO];
   assign os      = shin_r[`QHSC_OUTSEL_HI:`QHSC_OUTSEL_LO];
   always_comb begin
      status_word = 16'h0;
      status_word[`QHSC_UVWARN_BIT] = undervoltage;
      status_word[`QHSC_OVWARN_BIT] = overvoltage;
      status_word[11:8] = oc_latch_r;
      status_word[7:4]  = ol_flag_r;
      status_word[`QHSC_UVF_BIT] = uv_flag_r;
      status_word[`QHSC_OVF_BIT] = ov_flag_r;
      status_word[0] = |stat_sel_r;
   end
   // Shift in MSB first, shift out status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shin_r  <= 16'h0;
         shout_r <= 16'h0;
         cnt_r   <= 8'h0;
      end else if (cs_fall) begin
         shout_r <= status_word;
         cnt_r   <= 8'h0;
      end else if (!cs_s_r[1] && rise) begin
         shin_r  <= {shin_r[14:0], mosi_s_r[1]};
         cnt_r   <= cnt_r + 8'h1;
      end else if (!cs_s_r[1] && fall) begin
         shout_r <= {shout_r[14:0], shin_r[15]};
      end
   end
   assign link.miso = shout_r[15];
   // Register writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_sel_r <= 5'h0; spi_on_r <= 4'h0; sense_en_r <= 4'h0;
         oc_level_r <= 16'h0; blank_cfg_r <= 16'h0; direct_cfg_r <= 16'h0;
         vprot_dis_r <= 2'h0; wd_timeout_r <= 2'h0; wd_refresh_r <= 1'b0;
      end else if (word_ok) begin
         wd_refresh_r <= shin_r[`QHSC_WD_BIT];
         case (qhsc_sel_type'(sel))
            QHSC_SEL_STATUS: stat_sel_r <= shin_r[4:0];
            QHSC_SEL_OUTPUT:
               if (shin_r[`QHSC_OUTSEL_LO]) sense_en_r <= shin_r[3:0];
               else spi_on_r <= shin_r[3:0];
            QHSC_SEL_OCLVL:  oc_level_r[os*4 +: 4] <= shin_r[3:0];
            QHSC_SEL_BLANK:  blank_cfg_r[os*4 +: 4] <= shin_r[3:0];
            QHSC_SEL_DIRECT: direct_cfg_r[os*4 +: 4] <= shin_r[3:0];
            QHSC_SEL_VPROT:
               if (shin_r[`QHSC_OUTSEL_LO]) wd_timeout_r <= shin_r[1:0];
               else vprot_dis_r <= shin_r[1:0];
            default: ;
         endcase
      end
   end
   // Requested state per output with direct input mixing
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (direct_cfg_r[i*4+1]) req_on[i] = spi_on_r[i];
         else if (direct_cfg_r[i*4]) req_on[i] = spi_on_r[i] & direct_in[i];
         else req_on[i] = spi_on_r[i] | direct_in[i];
      end
   end
   // Open-load report masked where detection is off
   always_comb begin
      for (int i = 0; i < 4; i++) ol_en[i] = !blank_cfg_r[i*4+3];
   end
   // Faults
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ov_flag_r <= 1'b0; uv_flag_r <= 1'b0; uv_latch_r <= 1'b0;
         oc_latch_r <= 4'h0; ol_flag_r <= 4'h0; on_prev_r <= 4'h0;
         for (int i = 0; i < 4; i++) blank_cnt_r[i] <= 23'h0;
      end else begin
         on_prev_r <= req_on;
         if (cs_fall) begin // set wins below
            ov_flag_r <= 1'b0;
            uv_flag_r <= 1'b0;
            ol_flag_r <= 4'h0;
         end
         if (overvoltage && !vprot_dis_r[0]) ov_flag_r <= 1'b1;
         if (undervoltage && !vprot_dis_r[1]) begin
            uv_flag_r <= 1'b1;
            uv_latch_r <= direct_in[1:0] != 2'h0;
         end else if (req_on == 4'h0) uv_latch_r <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            if (!req_on[i] && !out_on_r[i] && open_load[i] && !blank_cfg_r[i*4+3])
               ol_flag_r[i] <= 1'b1;
            if (req_on[i] && !on_prev_r[i]) oc_latch_r[i] <= 1'b0;
            if (out_on_r[i] && oc_high_hit[i]) oc_latch_r[i] <= 1'b1;
            if (out_on_r[i] && oc_low_hit[i] && !blank_cfg_r[i*4+2]) begin
               blank_cnt_r[i] <= blank_cnt_r[i] + 23'h1;
               case (blank_cfg_r[i*4 +: 2])
                  2'h3: if (blank_cnt_r[i] >= 23'(BLANK_150US)) oc_latch_r[i] <= 1'b1;
                  2'h2: if (blank_cnt_r[i] >= 23'(BLANK_75MS)) oc_latch_r[i] <= 1'b1;
                  default: if (blank_cnt_r[i] >= 23'(BLANK_155MS)) oc_latch_r[i] <= 1'b1;
               endcase
            end else blank_cnt_r[i] <= 23'h0;
         end
      end
   end
   // Output drive and fault pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_on_r <= 4'h0;
         fault_status_out_n_r <= 1'b1;
      end else begin
         for (int i = 0; i < 4; i++)
            out_on_r[i] <= req_on[i] && !oc_latch_r[i] && !oc_high_hit[i]
               && !(overvoltage && !vprot_dis_r[0])
               && !(undervoltage && !vprot_dis_r[1]) && !uv_latch_r;
         fault_status_out_n_r <= !(overvoltage || undervoltage || uv_latch_r
            || (|oc_latch_r) || (|(open_load & ~req_on & ol_en)));
      end
   end
endmodule : qhsc_device

// *** hdl/qhsc_defines.svh ***
// Purpose: Constants for the quad high-side switch command link
// Assumes: 16-bit words, MSB first
// Notes:   Bit positions of the command word, register offsets and blanking counts
`ifndef QHSC_DEFINES_SVH
`define QHSC_DEFINES_SVH
`define QHSC_WORD_BITS      16
`define QHSC_WD_BIT         15
`define QHSC_OUTSEL_HI      12
`define QHSC_OUTSEL_LO      11
`define QHSC_SEL_HI         10
`define QHSC_SEL_LO         8
`define QHSC_UVWARN_BIT     14
`define QHSC_OVWARN_BIT     13
`define QHSC_OVF_BIT        1
`define QHSC_UVF_BIT        2
`define QHSC_LINK_DIV       4
`define QHSC_BLANK_150US    6000
`define QHSC_BLANK_75MS     3000000
`define QHSC_BLANK_155MS    6200000
`define QHSC_REG_CMD        5'h00
`define QHSC_REG_CTRL       5'h04
`define QHSC_REG_STATUS     5'h08
`define QHSC_REG_RDATA      5'h0c
`endif

// *** hdl/qhsc_pkg.sv ***
// Purpose: Types for the quad high-side switch command link
// Assumes: Nothing
// Notes:   Select codes of the command word
package qhsc_pkg;
   typedef enum logic [2:0] {
      QHSC_SEL_STATUS = 3'h0,
      QHSC_SEL_OUTPUT = 3'h1,
      QHSC_SEL_OCLVL  = 3'h2,
      QHSC_SEL_BLANK  = 3'h3,
      QHSC_SEL_DIRECT = 3'h4,
      QHSC_SEL_VPROT  = 3'h5,
      QHSC_SEL_NOACT  = 3'h6,
      QHSC_SEL_TEST   = 3'h7
   } qhsc_sel_type;
   typedef enum logic [1:0] {
      QHSC_M_IDLE  = 2'h0,
      QHSC_M_SHIFT = 2'h1,
      QHSC_M_DONE  = 2'h2
   } qhsc_mst_type;
endpackage : qhsc_pkg

// *** hdl/qhsc_if.sv ***
// Purpose: SPI link between controller and switch
// Assumes: Controller drives clock, select and data in
// Notes:   Plain unidirectional wires
interface qhsc_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic rst_n;
   modport ctrl (output sclk, output cs_n, output mosi, output rst_n, input miso);
   modport dev  (input sclk, input cs_n, input mosi, input rst_n, output miso);
endinterface : qhsc_if

// *** hdl/qhsc_ctrl.sv ***
// Purpose: SPI master sending command words to the switch
// Assumes: Software reaches it over AXI4-Lite
// Notes:   Link clock is aclk divided; watchdog bit toggled per word
`include "qhsc_defines.svh"
module qhsc_ctrl
   import qhsc_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Link
   qhsc_if.ctrl             link
);
   logic [14:0]  cmd_r;
   logic         wd_r, busy_r, go_r, aw_r, w_r, dev_rst_r;
   logic [4:0]   awa_r;
   logic [31:0]  wd_data_r;
   logic [15:0]  tx_r, rx_r;
   logic [4:0]   bit_r;
   logic [7:0]   div_r;
   logic [1:0]   miso_s_r;
   qhsc_mst_type st_r;
   // Write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_r <= 1'b0; w_r <= 1'b0; awa_r <= 5'h0; wd_data_r <= 32'h0;
         s_axi_bvalid <= 1'b0; go_r <= 1'b0; cmd_r <= 15'h0; dev_rst_r <= 1'b0;
      end else begin
         go_r <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin aw_r <= 1'b1; awa_r <= s_axi_awaddr; end
         if (s_axi_wvalid && s_axi_wready) begin w_r <= 1'b1; wd_data_r <= s_axi_wdata; end
         if (aw_r && w_r && !s_axi_bvalid) begin
            aw_r <= 1'b0; w_r <= 1'b0; s_axi_bvalid <= 1'b1;
            if (awa_r == `QHSC_REG_CMD && !busy_r) begin
               cmd_r <= wd_data_r[14:0]; go_r <= 1'b1;
            end
            if (awa_r == `QHSC_REG_CTRL) dev_rst_r <= wd_data_r[0];
         end
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_awready = !aw_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_r && !s_axi_bvalid;
   assign s_axi_bresp   = 2'h0;
   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            `QHSC_REG_CMD:    s_axi_rdata <= {17'h0, cmd_r};
            `QHSC_REG_CTRL:   s_axi_rdata <= {31'h0, dev_rst_r};
            `QHSC_REG_STATUS: s_axi_rdata <= {30'h0, wd_r, busy_r};
            `QHSC_REG_RDATA:  s_axi_rdata <= {16'h0, rx_r};
            default:          s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
   end
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = 2'h0;
   // Shifter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= QHSC_M_IDLE; busy_r <= 1'b0; wd_r <= 1'b0; tx_r <= 16'h0;
         rx_r <= 16'h0; bit_r <= 5'h0; div_r <= 8'h0; miso_s_r <= 2'h0;
         link.sclk <= 1'b0; link.cs_n <= 1'b1; link.mosi <= 1'b0;
      end else begin
         miso_s_r <= {miso_s_r[0], link.miso};
         case (st_r)
            QHSC_M_IDLE: if (go_r) begin
               wd_r <= !wd_r;
               tx_r <= {!wd_r, cmd_r};
               link.cs_n <= 1'b0; busy_r <= 1'b1; bit_r <= 5'h0; div_r <= 8'h0;
               st_r <= QHSC_M_SHIFT;
            end
            QHSC_M_SHIFT: begin
               div_r <= div_r + 8'h1;
               if (div_r == 8'(`QHSC_LINK_DIV)) link.mosi <= tx_r[15];
               if (div_r == 8'(2 * `QHSC_LINK_DIV)) link.sclk <= 1'b1;
               if (div_r == 8'(3 * `QHSC_LINK_DIV)) begin
                  link.sclk <= 1'b0;
                  rx_r <= {rx_r[14:0], miso_s_r[1]};
                  tx_r <= {tx_r[14:0], 1'b0};
               end
               if (div_r == 8'(4 * `QHSC_LINK_DIV)) begin
                  div_r <= 8'h0;
                  bit_r <= bit_r + 5'h1;
                  if (bit_r == 5'(`QHSC_WORD_BITS - 1)) st_r <= QHSC_M_DONE;
               end
            end
            QHSC_M_DONE: begin
               link.cs_n <= 1'b1; busy_r <= 1'b0; st_r <= QHSC_M_IDLE;
            end
            default: st_r <= QHSC_M_IDLE;
         endcase
      end
   end
   assign link.rst_n = dev_rst_r | 1'b1;
endmodule : qhsc_ctrl

// *** tb/qhsc_checker.sv ***
// Purpose: Protocol checks on the switch link
// Assumes: Controller makes link clock and select
// Notes:   Bit counter and watchdog bit tracked per frame
module qhsc_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic rst_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] bits_r;
   logic       sclk_d_r;
   logic       wd_r;
   logic       wd_prev_r;
   logic       wd_ok_r;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      sclk_d_r <= sclk;
      if (!aresetn || cs_n) bits_r <= 5'h00;
      else if (sclk && !sclk_d_r) bits_r <= bits_r + 5'h01;
   end
   // First bit of a frame is the watchdog bit
   always_ff @(posedge aclk) begin
      if (!aresetn) wd_ok_r <= 1'b0;
      else if ($rose(cs_n)) wd_ok_r <= 1'b1;
      if (!cs_n && sclk && !sclk_d_r && bits_r == 5'h00) wd_r <= mosi;
      if ($rose(cs_n)) wd_prev_r <= wd_r;
   end
   sequence frame_open;
      $fell(cs_n);
   endsequence
   sequence frame_close;
      $rose(cs_n);
   endsequence
   AST_RST_HELD: assert property (!cs_n |-> rst_n)
      else $error("reset low in frame");
   AST_CLK_IN_FRAME: assert property ($rose(sclk) |-> !cs_n)
      else $error("link clock edge outside frame");
   AST_MOSI_STEADY: assert property (!cs_n && sclk && sclk_d_r |-> $stable(mosi))
      else $error("data moved while clock high");
   AST_FRAME_16: assert property (frame_close |-> bits_r == 5'h10)
      else $error("frame not 16 bits");
   AST_WD_TOGGLE: assert property (frame_close and wd_ok_r |-> wd_r != wd_prev_r)
      else $error("watchdog bit not toggled");
   AST_FRAME_LEN: assert property (frame_open |-> ##[240:300] frame_close)
      else $error("frame length wrong");
   AST_BIT_SPACING: assert property ($rose(sclk) |=> (!$rose(sclk)) [*8])
      else $error("link clock too fast");
   AST_IDLE_STILL: assert property (cs_n && $past(cs_n) |-> !sclk)
      else $error("link clock not idle low");
endmodule : qhsc_checker

// *** tb/test_quad_highside_spi_fault_ctrl.sv ***
// Purpose: Bench joining controller and switch over the link
// Assumes: Register offsets CMD 00, STATUS 08, RDATA 0c
// Notes:   Blanking shortened to 20 cycles
module test_quad_highside_spi_fault_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awv, wv, bready, arv, rready, awr, wr_, bv, arr, rv;
   logic [4:0]  awa, ara;
   logic [31:0] wd, rd_d;
   logic [1:0]  bresp, rresp;
   logic        ov, uv, wd_ref, fault_n;
   logic [3:0]  ol, och, ocl, din, out_on, sense;
   logic [15:0] oclvl, dcfg;
   logic [1:0]  wdto;
   int          error_cnt, n_tests, cyc;
   qhsc_if link_bus ();
   qhsc_ctrl i_qhsc_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
      .link(link_bus.ctrl));
   qhsc_device #(.BLANK_150US(20), .BLANK_75MS(20), .BLANK_155MS(20)) i_qhsc_device (
      .aclk(aclk), .aresetn(aresetn), .link(link_bus.dev), .overvoltage(ov),
      .undervoltage(uv), .open_load(ol), .oc_low_hit(ocl), .oc_high_hit(och),
      .direct_in(din), .out_on_r(out_on), .sense_en_r(sense), .oc_level_r(oclvl),
      .direct_cfg_r(dcfg), .wd_timeout_r(wdto), .wd_refresh_r(wd_ref),
      .fault_status_out_n_r(fault_n));
   qhsc_checker i_qhsc_checker (.aclk(aclk), .aresetn(aresetn), .sclk(link_bus.sclk),
      .cs_n(link_bus.cs_n), .mosi(link_bus.mosi), .miso(link_bus.miso),
      .rst_n(link_bus.rst_n));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [31:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge aclk);
         if (!ad && awr) begin ad = 1'b1; awv <= 1'b0; end
         if (!dd && wr_) begin dd = 1'b1; wv <= 1'b0; end
      end while (!(ad && dd));
      bready <= 1'b1;
      do @(posedge aclk); while (bv !== 1'b1);
      chk("bresp", 32'h0, bresp);
      bready <= 1'b0;
   endtask : wr
   task rd(input logic [4:0] a, output logic [31:0] d);
      ara <= a;
      arv <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rv !== 1'b1);
      d = rd_d;
      chk("rresp", 32'h0, rresp);
      rready <= 1'b0;
   endtask : rd
   task xfer(input logic [2:0] s, input logic [1:0] o, input logic [4:0] p);
      logic [31:0] d;
      wr(5'h00, {16'h0, 3'b000, o, s, 3'b111, p});
      repeat (4) @(posedge aclk);
      do rd(5'h08, d); while (d[0] !== 1'b0);
      repeat (8) @(posedge aclk);
   endtask : xfer
   task stat(output logic [31:0] d);
      xfer(3'h0, 2'h0, 5'h00);
      rd(5'h0c, d);
   endtask : stat
   task t_regs;
      xfer(3'h1, 2'h0, 5'h1a);
      chk("out_on", 32'ha, out_on);
      xfer(3'h1, 2'h1, 5'h06);
      chk("sense", 32'h6, sense);
      xfer(3'h2, 2'h2, 5'h15);
      chk("oc_level", 32'h5, oclvl[11:8]);
      xfer(3'h4, 2'h3, 5'h0c);
      chk("direct_cfg", 32'hc, dcfg[15:12]);
      xfer(3'h5, 2'h1, 5'h02);
      chk("wd_timeout", 32'h2, wdto);
      xfer(3'h6, 2'h3, 5'h1f);
      xfer(3'h7, 2'h3, 5'h1f);
      chk("regs_kept", 32'ha6c58000, {out_on, sense, dcfg[15:12], oclvl[11:8],
         wdto, 6'h0, 8'h0});
      $display("test regs done");
   endtask : t_regs
   task t_ov;
      logic [31:0] d;
      ov <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("ov_off", 32'h0, out_on);
      chk("fault_n", 32'h0, fault_n);
      stat(d);
      chk("ov_flag", 32'h1, d[1]);
      ov <= 1'b0;
      repeat (6) @(posedge aclk);
      chk("ov_back", 32'ha, out_on);
      chk("fault_n", 32'h1, fault_n);
      stat(d);
      chk("ov_latched", 32'h1, d[1]);
      stat(d);
      chk("ov_clear", 32'h0, d[1]);
      xfer(3'h5, 2'h0, 5'h01);
      ov <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("overvoltage_disable_on", 32'ha, out_on);
      stat(d);
      chk("ov_warn", 32'h1, d[13]);
      chk("overvoltage_disable_flag", 32'h0, d[1]);
      ov <= 1'b0;
      xfer(3'h5, 2'h0, 5'h00);
      $display("test ov done");
   endtask : t_ov
   task t_oc;
      och <= 4'h2;
      repeat (2) @(posedge aclk);
      och <= 4'h0;
      repeat (6) @(posedge aclk);
      chk("oc_off", 32'h8, out_on);
      chk("oc_pin", 32'h0, fault_n);
      xfer(3'h1, 2'h0, 5'h0a);
      chk("oc_held", 32'h8, out_on);
      xfer(3'h1, 2'h0, 5'h00);
      xfer(3'h1, 2'h0, 5'h0a);
      chk("oc_rearm", 32'ha, out_on);
      ocl <= 4'h8;
      repeat (10) @(posedge aclk);
      chk("ocl_blank", 32'ha, out_on);
      repeat (20) @(posedge aclk);
      chk("ocl_off", 32'h2, out_on);
      ocl <= 4'h0;
      xfer(3'h1, 2'h0, 5'h00);
      xfer(3'h1, 2'h0, 5'h0a);
      chk("ocl_rearm", 32'ha, out_on);
      $display("test oc done");
   endtask : t_oc
   task t_ol;
      logic [31:0] d;
      logic        p;
      ol <= 4'h1;
      repeat (40) @(posedge aclk);
      stat(d);
      stat(d);
      chk("ol_flag", 32'h1, d[4]);
      chk("ol_pin", 32'h0, fault_n);
      xfer(3'h3, 2'h0, 5'h08);
      stat(d);
      stat(d);
      chk("ol_dis", 32'h0, d[4]);
      chk("ol_dis_pin", 32'h1, fault_n);
      ol <= 4'h0;
      p = wd_ref;
      xfer(3'h6, 2'h0, 5'h00);
      chk("wd_bit", {31'h0, ~p}, wd_ref);
      rd(5'h10, d);
      chk("unmapped", 32'h0, d);
      $display("test ol done");
   endtask : t_ol
   task t_uv;
      logic [31:0] d;
      din <= 4'h2;
      uv <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("uv_off", 32'h0, out_on);
      uv <= 1'b0;
      din <= 4'h0;
      repeat (6) @(posedge aclk);
      chk("uv_latched", 32'h0, out_on);
      chk("uv_pin", 32'h0, fault_n);
      xfer(3'h1, 2'h0, 5'h00);
      xfer(3'h1, 2'h0, 5'h0a);
      chk("uv_rearm", 32'ha, out_on);
      uv <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("uv_nl_off", 32'h0, out_on);
      uv <= 1'b0;
      repeat (6) @(posedge aclk);
      chk("uv_nl_back", 32'ha, out_on);
      xfer(3'h5, 2'h0, 5'h02);
      uv <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("undervoltage_disable_on", 32'ha, out_on);
      stat(d);
      chk("uv_warn", 32'h1, d[14]);
      chk("undervoltage_disable_flag", 32'h0, d[2]);
      uv <= 1'b0;
      xfer(3'h5, 2'h0, 5'h00);
      $display("test uv done");
   endtask : t_uv
   task wrap_up;
      $display("tests %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      {aresetn, awv, wv, bready, arv, rready, ov, uv} = 8'h00;
      {awa, ara, wd, ol, och, ocl, din} = 58'h0;
      error_cnt = 0;
      n_tests = 0;
      cyc = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_ov();
      t_oc();
      t_ol();
      t_uv();
      wrap_up();
   end
endmodule : test_quad_highside_spi_fault_ctrl
